/* File: design/rcso_pkg.sv */
// Package for the receive checksum-offload statistics block: map, fields, types
package rcso_pkg;
	// ------------------------------------------------------------
	// Counter numbering and geometry
	// ------------------------------------------------------------
	localparam int RCSO_NUM_CNT = 12;
	localparam int RCSO_ADDR_W = 12;
	localparam int RCSO_DATA_W = 32;
	localparam int RCSO_LEN_W = 16;

	localparam int RCSO_IPV4_OK = 0;
	localparam int RCSO_IPV4_HDR_BAD = 1;
	localparam int RCSO_IPV6_OK = 2;
	localparam int RCSO_IPV6_HDR_BAD = 3;
	localparam int RCSO_UDP_FRM = 4;
	localparam int RCSO_TCP_FRM = 5;
	localparam int RCSO_ICMP_FRM = 6;
	localparam int RCSO_IPV4_BYTES = 7;
	localparam int RCSO_IPV6_BYTES = 8;
	localparam int RCSO_UDP_BYTES = 9;
	localparam int RCSO_TCP_BYTES = 10;
	localparam int RCSO_ICMP_BYTES = 11;

	// ------------------------------------------------------------
	// Register offsets (byte addresses)
	// ------------------------------------------------------------
	localparam logic [11:0] RCSO_MASK_OFS = 12'h200;
	localparam logic [11:0] RCSO_STATUS_OFS = 12'h208;
	localparam logic [11:0] RCSO_CNT_OFS [RCSO_NUM_CNT] = '{
		12'h210, 12'h214, 12'h224, 12'h228, 12'h234, 12'h23C,
		12'h244, 12'h254, 12'h268, 12'h274, 12'h27C, 12'h284};

	// Status and mask bit position of each counter
	localparam int RCSO_STAT_BIT [RCSO_NUM_CNT] = '{
		0, 1, 5, 6, 9, 11, 13, 17, 22, 25, 27, 29};

	// Implemented status and mask bits; all others read zero
	localparam logic [31:0] RCSO_FLAG_VALID = 32'h2A422A63;

	// ------------------------------------------------------------
	// Reset values and thresholds
	// ------------------------------------------------------------
	localparam logic [31:0] RCSO_CNT_RESET = 32'h00000000;
	localparam logic [31:0] RCSO_FLAG_RESET = 32'h00000000;
	localparam logic [32:0] RCSO_HALF_SCALE = 33'h080000000;
	localparam logic [32:0] RCSO_FULL_SCALE = 33'h0FFFFFFFF;
	localparam logic [31:0] RCSO_ONE = 32'h00000001;

	// ------------------------------------------------------------
	// Carriers
	// ------------------------------------------------------------
	// One classified frame from the checksum-offload engine
	typedef struct packed {
		logic valid;
		logic ipv4_ok;
		logic ipv4_hdr_bad;
		logic ipv6_ok;
		logic ipv6_hdr_bad;
		logic udp_err;
		logic tcp_err;
		logic icmp_err;
		logic [15:0] ip_len;
		logic [15:0] seg_len;
	} rcso_rx_event_t;

	// Register port request
	typedef struct packed {
		logic wr_en;
		logic rd_en;
		logic [11:0] addr;
		logic [31:0] wdata;
	} rcso_reg_req_t;
endpackage : rcso_pkg

/* File: design/rcso_stats.sv */
// Receive checksum-offload statistics counters with threshold status and mask
`timescale 1ns/10ps
`default_nettype none

module rcso_stats (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire rcso_pkg::rcso_rx_event_t rx_event,
	input wire rcso_pkg::rcso_reg_req_t reg_req,
	output logic [31:0] reg_rdata,
	output logic irq
);
	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	logic [31:0] count [rcso_pkg::RCSO_NUM_CNT];
	logic [31:0] next_count [rcso_pkg::RCSO_NUM_CNT];
	logic [31:0] status;
	logic [31:0] next_status;
	logic [31:0] mask;
	logic [31:0] next_mask;
	logic [31:0] next_rdata;
	logic [31:0] amount [rcso_pkg::RCSO_NUM_CNT];
	logic [rcso_pkg::RCSO_NUM_CNT-1:0] bump;
	logic [rcso_pkg::RCSO_NUM_CNT-1:0] wr_hit;
	logic [rcso_pkg::RCSO_NUM_CNT-1:0] half_hit;
	logic [rcso_pkg::RCSO_NUM_CNT-1:0] full_hit;
	logic status_rd;

	// ------------------------------------------------------------
	// Amount added per counter for the current event
	// ------------------------------------------------------------
	// Classification flags are trusted as given by the offload engine
	always_comb begin
		for (int i = 0; i < rcso_pkg::RCSO_NUM_CNT; i++) begin
			amount[i] = '0;
		end
		if (rx_event.valid) begin
			if (rx_event.ipv4_ok) begin
				amount[rcso_pkg::RCSO_IPV4_OK] = rcso_pkg::RCSO_ONE;
			end
			if (rx_event.ipv4_hdr_bad) begin
				amount[rcso_pkg::RCSO_IPV4_HDR_BAD] = rcso_pkg::RCSO_ONE;
				amount[rcso_pkg::RCSO_IPV4_BYTES] = {16'h0000, rx_event.ip_len};
			end
			if (rx_event.ipv6_ok) begin
				amount[rcso_pkg::RCSO_IPV6_OK] = rcso_pkg::RCSO_ONE;
			end
			if (rx_event.ipv6_hdr_bad) begin
				amount[rcso_pkg::RCSO_IPV6_HDR_BAD] = rcso_pkg::RCSO_ONE;
				amount[rcso_pkg::RCSO_IPV6_BYTES] = {16'h0000, rx_event.ip_len};
			end
			if (rx_event.udp_err) begin
				amount[rcso_pkg::RCSO_UDP_FRM] = rcso_pkg::RCSO_ONE;
				amount[rcso_pkg::RCSO_UDP_BYTES] = {16'h0000, rx_event.seg_len};
			end
			if (rx_event.tcp_err) begin
				amount[rcso_pkg::RCSO_TCP_FRM] = rcso_pkg::RCSO_ONE;
				amount[rcso_pkg::RCSO_TCP_BYTES] = {16'h0000, rx_event.seg_len};
			end
			if (rx_event.icmp_err) begin
				amount[rcso_pkg::RCSO_ICMP_FRM] = rcso_pkg::RCSO_ONE;
				amount[rcso_pkg::RCSO_ICMP_BYTES] = {16'h0000, rx_event.seg_len};
			end
		end
	end

	// ------------------------------------------------------------
	// Next values of counters, status, mask and read data
	// ------------------------------------------------------------
	// A software write to a counter wins over a same-cycle event,
	// so a cleared counter never starts from a stale sum.
	always_comb begin
		logic [32:0] sum;
		sum = '0;
		next_status = status;
		next_mask = mask;
		next_rdata = '0;
		status_rd = reg_req.rd_en && (reg_req.addr == rcso_pkg::RCSO_STATUS_OFS);
		// Read clears; events below still set, so none is lost
		if (status_rd) begin
			next_status = rcso_pkg::RCSO_FLAG_RESET;
		end
		if (reg_req.wr_en && (reg_req.addr == rcso_pkg::RCSO_MASK_OFS)) begin
			next_mask = reg_req.wdata & rcso_pkg::RCSO_FLAG_VALID;
		end
		for (int i = 0; i < rcso_pkg::RCSO_NUM_CNT; i++) begin
			sum = {1'b0, count[i]} + {1'b0, amount[i]};
			bump[i] = (amount[i] != '0);
			wr_hit[i] = reg_req.wr_en && (reg_req.addr == rcso_pkg::RCSO_CNT_OFS[i]);
			// Crossing tests catch byte adds that jump over the mark
			half_hit[i] = bump[i] && ({1'b0, count[i]} < rcso_pkg::RCSO_HALF_SCALE)
				&& (sum >= rcso_pkg::RCSO_HALF_SCALE);
			full_hit[i] = bump[i] && (sum >= rcso_pkg::RCSO_FULL_SCALE);
			if (wr_hit[i]) begin
				next_count[i] = reg_req.wdata;
			end else begin
				next_count[i] = sum[31:0];
			end
			if (!wr_hit[i] && (half_hit[i] || full_hit[i])) begin
				next_status[rcso_pkg::RCSO_STAT_BIT[i]] = 1'b1;
			end
		end
		// Address decode for reads; unmapped offsets return zero
		if (reg_req.rd_en) begin
			if (reg_req.addr == rcso_pkg::RCSO_MASK_OFS) begin
				next_rdata = mask;
			end else if (status_rd) begin
				next_rdata = status & rcso_pkg::RCSO_FLAG_VALID;
			end else begin
				for (int i = 0; i < rcso_pkg::RCSO_NUM_CNT; i++) begin
					if (reg_req.addr == rcso_pkg::RCSO_CNT_OFS[i]) begin
						next_rdata = count[i];
					end
				end
			end
		end
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			for (int i = 0; i < rcso_pkg::RCSO_NUM_CNT; i++) begin
				count[i] <= rcso_pkg::RCSO_CNT_RESET;
			end
			status <= rcso_pkg::RCSO_FLAG_RESET;
			mask <= rcso_pkg::RCSO_FLAG_RESET;
			reg_rdata <= '0;
		end else begin
			for (int i = 0; i < rcso_pkg::RCSO_NUM_CNT; i++) begin
				count[i] <= next_count[i];
			end
			status <= next_status;
			mask <= next_mask;
			reg_rdata <= next_rdata;
		end
	end

	// ------------------------------------------------------------
	// Interrupt output
	// ------------------------------------------------------------
	// Mask gates only the output; software still sees the raw status
	assign irq = |(status & ~mask & rcso_pkg::RCSO_FLAG_VALID);

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	AST_IPV4_OK_COUNT: assert property (@(posedge core_clk) disable iff (!reset_n)
		rx_event.valid && rx_event.ipv4_ok && !wr_hit[rcso_pkg::RCSO_IPV4_OK]
		|=> count[rcso_pkg::RCSO_IPV4_OK] == $past(count[rcso_pkg::RCSO_IPV4_OK]) + 32'h00000001)
		else $error("good IPv4 counter did not step by one");

	AST_IPV4_HDR_COUNT: assert property (@(posedge core_clk) disable iff (!reset_n)
		rx_event.valid && rx_event.ipv4_hdr_bad && !wr_hit[rcso_pkg::RCSO_IPV4_HDR_BAD]
		|=> count[rcso_pkg::RCSO_IPV4_HDR_BAD]
			== $past(count[rcso_pkg::RCSO_IPV4_HDR_BAD]) + 32'h00000001)
		else $error("IPv4 header-error counter did not step");

	AST_IPV6_IDLE_HOLD: assert property (@(posedge core_clk) disable iff (!reset_n)
		!rx_event.valid && !reg_req.wr_en
		|=> $stable(count[rcso_pkg::RCSO_IPV6_OK]) && $stable(count[rcso_pkg::RCSO_IPV6_HDR_BAD]))
		else $error("IPv6 counter moved without an event");

	AST_UDP_FRAME_COUNT: assert property (@(posedge core_clk) disable iff (!reset_n)
		rx_event.valid && rx_event.udp_err && !wr_hit[rcso_pkg::RCSO_UDP_FRM]
		|=> count[rcso_pkg::RCSO_UDP_FRM] == $past(count[rcso_pkg::RCSO_UDP_FRM]) + 32'h00000001)
		else $error("UDP error frame counter did not step");

	AST_IPV4_BYTE_ADD: assert property (@(posedge core_clk) disable iff (!reset_n)
		rx_event.valid && rx_event.ipv4_hdr_bad && !wr_hit[rcso_pkg::RCSO_IPV4_BYTES]
		|=> count[rcso_pkg::RCSO_IPV4_BYTES] == $past(count[rcso_pkg::RCSO_IPV4_BYTES])
			+ {16'h0000, $past(rx_event.ip_len)})
		else $error("IPv4 header-error bytes not added");

	AST_TCP_BYTE_ADD: assert property (@(posedge core_clk) disable iff (!reset_n)
		rx_event.valid && rx_event.tcp_err && !wr_hit[rcso_pkg::RCSO_TCP_BYTES]
		|=> count[rcso_pkg::RCSO_TCP_BYTES] == $past(count[rcso_pkg::RCSO_TCP_BYTES])
			+ {16'h0000, $past(rx_event.seg_len)})
		else $error("TCP error bytes not added");

	AST_WRAP_ZERO: assert property (@(posedge core_clk) disable iff (!reset_n)
		count[rcso_pkg::RCSO_ICMP_FRM] == 32'hFFFFFFFF && rx_event.valid && rx_event.icmp_err
		&& !wr_hit[rcso_pkg::RCSO_ICMP_FRM]
		|=> count[rcso_pkg::RCSO_ICMP_FRM] == 32'h00000000 && status[13])
		else $error("ICMP frame counter did not wrap to zero");

	AST_HALF_SETS_BIT0: assert property (@(posedge core_clk) disable iff (!reset_n)
		count[rcso_pkg::RCSO_IPV4_OK] == 32'h7FFFFFFF && rx_event.valid && rx_event.ipv4_ok
		&& !wr_hit[rcso_pkg::RCSO_IPV4_OK]
		|=> status[0] ##1 (status[0] || $past(status_rd)))
		else $error("half scale did not raise status bit 0");

	AST_READ_CLEARS: assert property (@(posedge core_clk) disable iff (!reset_n)
		status_rd && !rx_event.valid
		|=> status == 32'h00000000 && (reg_rdata & ~rcso_pkg::RCSO_FLAG_VALID) == 32'h00000000)
		else $error("status read did not clear or showed reserved bits");

	AST_IRQ_MATCHES: assert property (@(posedge core_clk) disable iff (!reset_n)
		status[6] && !mask[6] |-> irq)
		else $error("unmasked status bit 6 without interrupt");

	AST_MASK_BLOCKS: assert property (@(posedge core_clk) disable iff (!reset_n)
		(status & ~mask) == 32'h00000000 |-> !irq)
		else $error("interrupt raised while every set bit is masked");

	AST_WRITE_LOADS: assert property (@(posedge core_clk) disable iff (!reset_n)
		wr_hit[rcso_pkg::RCSO_UDP_BYTES]
		|=> count[rcso_pkg::RCSO_UDP_BYTES] == $past(reg_req.wdata))
		else $error("counter write did not load");

	// ------------------------------------------------------------
	// Frame counters not covered above
	// ------------------------------------------------------------
	// Each frame flag must step its own counter by exactly one
	AST_IPV6_OK_COUNT: assert property (@(posedge core_clk) disable iff (!reset_n)
		rx_event.valid && rx_event.ipv6_ok && !wr_hit[rcso_pkg::RCSO_IPV6_OK]
		|=> count[rcso_pkg::RCSO_IPV6_OK] == $past(count[rcso_pkg::RCSO_IPV6_OK]) + 32'h00000001)
		else $error("good IPv6 counter did not step by one");

	AST_IPV6_HDR_COUNT: assert property (@(posedge core_clk) disable iff (!reset_n)
		rx_event.valid && rx_event.ipv6_hdr_bad && !wr_hit[rcso_pkg::RCSO_IPV6_HDR_BAD]
		|=> count[rcso_pkg::RCSO_IPV6_HDR_BAD]
			== $past(count[rcso_pkg::RCSO_IPV6_HDR_BAD]) + 32'h00000001)
		else $error("IPv6 header-error counter did not step");

	AST_TCP_FRAME_COUNT: assert property (@(posedge core_clk) disable iff (!reset_n)
		rx_event.valid && rx_event.tcp_err && !wr_hit[rcso_pkg::RCSO_TCP_FRM]
		|=> count[rcso_pkg::RCSO_TCP_FRM] == $past(count[rcso_pkg::RCSO_TCP_FRM]) + 32'h00000001)
		else $error("TCP error frame counter did not step");

	AST_ICMP_FRAME_COUNT: assert property (@(posedge core_clk) disable iff (!reset_n)
		rx_event.valid && rx_event.icmp_err && !wr_hit[rcso_pkg::RCSO_ICMP_FRM]
		|=> count[rcso_pkg::RCSO_ICMP_FRM]
			== $past(count[rcso_pkg::RCSO_ICMP_FRM]) + 32'h00000001)
		else $error("ICMP error frame counter did not step");

	// ------------------------------------------------------------
	// Byte counters not covered above
	// ------------------------------------------------------------
	// Byte adds take the length field of the same cycle, never a stale one
	AST_IPV6_BYTE_ADD: assert property (@(posedge core_clk) disable iff (!reset_n)
		rx_event.valid && rx_event.ipv6_hdr_bad && !wr_hit[rcso_pkg::RCSO_IPV6_BYTES]
		|=> count[rcso_pkg::RCSO_IPV6_BYTES] == $past(count[rcso_pkg::RCSO_IPV6_BYTES])
			+ {16'h0000, $past(rx_event.ip_len)})
		else $error("IPv6 header-error bytes not added");

	AST_UDP_BYTE_ADD: assert property (@(posedge core_clk) disable iff (!reset_n)
		rx_event.valid && rx_event.udp_err && !wr_hit[rcso_pkg::RCSO_UDP_BYTES]
		|=> count[rcso_pkg::RCSO_UDP_BYTES] == $past(count[rcso_pkg::RCSO_UDP_BYTES])
			+ {16'h0000, $past(rx_event.seg_len)})
		else $error("UDP error bytes not added");

	AST_ICMP_BYTE_ADD: assert property (@(posedge core_clk) disable iff (!reset_n)
		rx_event.valid && rx_event.icmp_err && !wr_hit[rcso_pkg::RCSO_ICMP_BYTES]
		|=> count[rcso_pkg::RCSO_ICMP_BYTES] == $past(count[rcso_pkg::RCSO_ICMP_BYTES])
			+ {16'h0000, $past(rx_event.seg_len)})
		else $error("ICMP error bytes not added");

	// ------------------------------------------------------------
	// Threshold flags
	// ------------------------------------------------------------
	// Stepping onto half or full scale must raise the counter's own status bit
	AST_HALF_SETS_BIT6: assert property (@(posedge core_clk) disable iff (!reset_n)
		count[rcso_pkg::RCSO_IPV6_HDR_BAD] == 32'h7FFFFFFF && rx_event.valid
		&& rx_event.ipv6_hdr_bad && !wr_hit[rcso_pkg::RCSO_IPV6_HDR_BAD]
		|=> status[6])
		else $error("half scale did not raise status bit 6");

	AST_HALF_SETS_BIT5: assert property (@(posedge core_clk) disable iff (!reset_n)
		count[rcso_pkg::RCSO_IPV6_OK] == 32'h7FFFFFFF && rx_event.valid
		&& rx_event.ipv6_ok && !wr_hit[rcso_pkg::RCSO_IPV6_OK]
		|=> status[5])
		else $error("half scale did not raise status bit 5");

	AST_HALF_SETS_BIT1: assert property (@(posedge core_clk) disable iff (!reset_n)
		count[rcso_pkg::RCSO_IPV4_HDR_BAD] == 32'h7FFFFFFF && rx_event.valid
		&& rx_event.ipv4_hdr_bad && !wr_hit[rcso_pkg::RCSO_IPV4_HDR_BAD]
		|=> status[1])
		else $error("half scale did not raise status bit 1");

	AST_FULL_SETS_BIT0: assert property (@(posedge core_clk) disable iff (!reset_n)
		count[rcso_pkg::RCSO_IPV4_OK] == 32'hFFFFFFFE && rx_event.valid
		&& rx_event.ipv4_ok && !wr_hit[rcso_pkg::RCSO_IPV4_OK]
		|=> status[0])
		else $error("full scale did not raise status bit 0");

	AST_BYTE_HALF_BIT17: assert property (@(posedge core_clk) disable iff (!reset_n)
		count[rcso_pkg::RCSO_IPV4_BYTES] == 32'h7FFFFFFF && rx_event.valid && rx_event.ipv4_hdr_bad
		&& rx_event.ip_len != 16'h0000 && !wr_hit[rcso_pkg::RCSO_IPV4_BYTES]
		|=> status[17])
		else $error("IPv4 byte half scale did not raise bit 17");

	AST_BYTE_HALF_BIT22: assert property (@(posedge core_clk) disable iff (!reset_n)
		count[rcso_pkg::RCSO_IPV6_BYTES] == 32'h7FFFFFFF && rx_event.valid && rx_event.ipv6_hdr_bad
		&& rx_event.ip_len != 16'h0000 && !wr_hit[rcso_pkg::RCSO_IPV6_BYTES]
		|=> status[22])
		else $error("IPv6 byte half scale did not raise bit 22");

	AST_BYTE_HALF_BIT25: assert property (@(posedge core_clk) disable iff (!reset_n)
		count[rcso_pkg::RCSO_UDP_BYTES] == 32'h7FFFFFFF && rx_event.valid && rx_event.udp_err
		&& rx_event.seg_len != 16'h0000 && !wr_hit[rcso_pkg::RCSO_UDP_BYTES]
		|=> status[25])
		else $error("UDP byte half scale did not raise bit 25");

	AST_BYTE_HALF_BIT27: assert property (@(posedge core_clk) disable iff (!reset_n)
		count[rcso_pkg::RCSO_TCP_BYTES] == 32'h7FFFFFFF && rx_event.valid && rx_event.tcp_err
		&& rx_event.seg_len != 16'h0000 && !wr_hit[rcso_pkg::RCSO_TCP_BYTES]
		|=> status[27])
		else $error("TCP byte half scale did not raise bit 27");

	AST_BYTE_HALF_BIT29: assert property (@(posedge core_clk) disable iff (!reset_n)
		count[rcso_pkg::RCSO_ICMP_BYTES] == 32'h7FFFFFFF && rx_event.valid && rx_event.icmp_err
		&& rx_event.seg_len != 16'h0000 && !wr_hit[rcso_pkg::RCSO_ICMP_BYTES]
		|=> status[29])
		else $error("ICMP byte half scale did not raise bit 29");

	AST_FRAME_HALF_BIT9: assert property (@(posedge core_clk) disable iff (!reset_n)
		count[rcso_pkg::RCSO_UDP_FRM] == 32'h7FFFFFFF && rx_event.valid && rx_event.udp_err
		&& !wr_hit[rcso_pkg::RCSO_UDP_FRM]
		|=> status[9])
		else $error("UDP frame half scale did not raise bit 9");

	AST_FRAME_HALF_BIT11: assert property (@(posedge core_clk) disable iff (!reset_n)
		count[rcso_pkg::RCSO_TCP_FRM] == 32'h7FFFFFFF && rx_event.valid && rx_event.tcp_err
		&& !wr_hit[rcso_pkg::RCSO_TCP_FRM]
		|=> status[11])
		else $error("TCP frame half scale did not raise bit 11");

	AST_FRAME_HALF_BIT13: assert property (@(posedge core_clk) disable iff (!reset_n)
		count[rcso_pkg::RCSO_ICMP_FRM] == 32'h7FFFFFFF && rx_event.valid && rx_event.icmp_err
		&& !wr_hit[rcso_pkg::RCSO_ICMP_FRM]
		|=> status[13])
		else $error("ICMP frame half scale did not raise bit 13");

	// ------------------------------------------------------------
	// Register port
	// ------------------------------------------------------------
	// With no event, write or read, the status word must not drift
	AST_STATUS_QUIET: assert property (@(posedge core_clk) disable iff (!reset_n)
		!rx_event.valid && !reg_req.wr_en && !reg_req.rd_en
		|=> $stable(status))
		else $error("status changed with no cause");

	AST_MASK_WRITE: assert property (@(posedge core_clk) disable iff (!reset_n)
		reg_req.wr_en && reg_req.addr == rcso_pkg::RCSO_MASK_OFS
		|=> mask == ($past(reg_req.wdata) & rcso_pkg::RCSO_FLAG_VALID))
		else $error("mask write did not keep only implemented bits");

	AST_STATUS_WRITE_IGNORED: assert property (@(posedge core_clk) disable iff (!reset_n)
		reg_req.wr_en && reg_req.addr == rcso_pkg::RCSO_STATUS_OFS && !rx_event.valid
		|=> $stable(status))
		else $error("write to status changed it");

	AST_RDATA_IDLE_ZERO: assert property (@(posedge core_clk) disable iff (!reset_n)
		!reg_req.rd_en
		|=> reg_rdata == 32'h00000000)
		else $error("read data stood without a read");

	AST_COUNT_READBACK: assert property (@(posedge core_clk) disable iff (!reset_n)
		reg_req.rd_en && reg_req.addr == rcso_pkg::RCSO_CNT_OFS[rcso_pkg::RCSO_IPV4_OK]
		|=> reg_rdata == $past(count[rcso_pkg::RCSO_IPV4_OK]))
		else $error("counter read returned a wrong value");
endmodule : rcso_stats

`default_nettype wire

/* File: verif/rcso_rx_source.sv */
// Behavioural model of the receive path that classifies frames for the block
`timescale 1ns/10ps
`default_nettype none

// --------------------
// Frame event source
// --------------------
module rcso_rx_source (
	input wire logic send,
	input wire logic [6:0] flags,
	input wire logic [15:0] ilen,
	input wire logic [15:0] slen,
	output var rcso_pkg::rcso_rx_event_t rx_event
);
	// Flags stay up when idle, so a block that ignores valid miscounts;
	// lengths invert when idle so stale values never pass as live ones
	always_comb begin
		rx_event = {send, flags, send ? ilen : ~ilen, send ? slen : ~slen};
	end
endmodule : rcso_rx_source
`default_nettype wire

/* File: verif/rcso_stats_tb.sv */
// Self-checking bench for the receive checksum-offload statistics block
`timescale 1ns/10ps
`default_nettype none

module rcso_stats_tb;
	typedef struct {
		logic [6:0] flags;
		logic [15:0] ilen;
		logic [15:0] slen;
		int bidx;
		logic [31:0] bexp;
	} rcso_row_t;
	logic core_clk, reset_n, send, irq;
	logic [6:0] flags;
	logic [15:0] ilen, slen;
	logic [31:0] reg_rdata, bmask;
	rcso_pkg::rcso_rx_event_t rx_event;
	rcso_pkg::rcso_reg_req_t reg_req;
	int err_total, total_checks;
	// One frame kind per row; byte column only where the kind has a byte counter
	rcso_row_t rows [7] = '{
		'{7'h40, 16'h0011, 16'h0022, 0, 32'h0}, '{7'h20, 16'h0033, 16'h0044, 7, 32'h33},
		'{7'h10, 16'h0011, 16'h0022, 0, 32'h0}, '{7'h08, 16'h0055, 16'h0066, 8, 32'h55},
		'{7'h04, 16'h0077, 16'h0088, 9, 32'h88}, '{7'h02, 16'h0099, 16'h00AA, 10, 32'hAA},
		'{7'h01, 16'h00BB, 16'h00CC, 11, 32'hCC}};
	logic [6:0] fl [12] = '{7'h40, 7'h20, 7'h10, 7'h08, 7'h04, 7'h02, 7'h01,
		7'h20, 7'h08, 7'h04, 7'h02, 7'h01};

	rcso_stats i_rcso_stats (.core_clk(core_clk), .reset_n(reset_n), .rx_event(rx_event),
		.reg_req(reg_req), .reg_rdata(reg_rdata), .irq(irq));
	rcso_rx_source i_rcso_rx_source (.send(send), .flags(flags), .ilen(ilen), .slen(slen),
		.rx_event(rx_event));

	// 200 MHz clock
	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end

	// --------------------
	// Shared tasks
	// --------------------
	task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_total++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge core_clk);
		reg_req <= '{wr_en: 1'b1, rd_en: 1'b0, addr: a, wdata: d};
		@(posedge core_clk);
		reg_req.wr_en <= 1'b0;
		#1;
	endtask : wr

	// Read data stands only in the cycle after the strobe
	task automatic rd(input logic [11:0] a, input logic [31:0] e, input string n);
		@(posedge core_clk);
		reg_req <= '{wr_en: 1'b0, rd_en: 1'b1, addr: a, wdata: 32'h0};
		@(posedge core_clk);
		reg_req.rd_en <= 1'b0;
		#1 chk(n, reg_rdata, e);
	endtask : rd

	task automatic ev(input logic [6:0] f, input logic [15:0] il, input logic [15:0] sl);
		@(posedge core_clk);
		send <= 1'b1;
		flags <= f;
		ilen <= il;
		slen <= sl;
		@(posedge core_clk);
		send <= 1'b0;
		#1;
	endtask : ev

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : print_verdict

	// Hang guard: far above the length of the sequence
	initial begin
		repeat (20000) @(posedge core_clk);
		err_total++;
		print_verdict();
	end

	// --------------------
	// Main sequence
	// --------------------
	initial begin
		reset_n = 1'b0;
		send = 1'b0;
		flags = 7'h00;
		ilen = 16'h0000;
		slen = 16'h0000;
		reg_req = '0;
		err_total = 0;
		total_checks = 0;
		repeat (5) @(posedge core_clk);
		reset_n <= 1'b1;
		for (int k = 0; k < rcso_pkg::RCSO_NUM_CNT; k++) begin
			rd(rcso_pkg::RCSO_CNT_OFS[k], 32'h0, "cnt_reset");
		end
		rd(rcso_pkg::RCSO_MASK_OFS, 32'h0, "mask_reset");
		rd(rcso_pkg::RCSO_STATUS_OFS, 32'h0, "stat_reset");
		$display("test reset done");
		// Each frame kind in turn; idle flags held high must not count
		foreach (rows[i]) begin
			ev(rows[i].flags, rows[i].ilen, rows[i].slen);
			rd(rcso_pkg::RCSO_CNT_OFS[i], 32'h1, "frames");
			if (rows[i].bidx != 0) begin
				rd(rcso_pkg::RCSO_CNT_OFS[rows[i].bidx], rows[i].bexp, "bytes");
			end
		end
		$display("test counting done");
		// Half scale and full scale with wrap, for every counter
		for (int k = 0; k < rcso_pkg::RCSO_NUM_CNT; k++) begin
			bmask = 32'h1 << rcso_pkg::RCSO_STAT_BIT[k];
			wr(rcso_pkg::RCSO_CNT_OFS[k], 32'h7FFFFFFF);
			ev(fl[k], 16'h0001, 16'h0001);
			chk("irq_half", {31'h0, irq}, 32'h1);
			rd(rcso_pkg::RCSO_STATUS_OFS, bmask, "stat_half");
			chk("irq_clear", {31'h0, irq}, 32'h0);
			wr(rcso_pkg::RCSO_CNT_OFS[k], 32'hFFFFFFFF);
			ev(fl[k], 16'h0001, 16'h0001);
			rd(rcso_pkg::RCSO_CNT_OFS[k], 32'h0, "wrap");
			rd(rcso_pkg::RCSO_STATUS_OFS, bmask, "stat_full");
		end
		$display("test thresholds done");
		// Masked flag still sets status but keeps the interrupt low
		wr(rcso_pkg::RCSO_MASK_OFS, 32'hFFFFFFFF);
		rd(rcso_pkg::RCSO_MASK_OFS, rcso_pkg::RCSO_FLAG_VALID, "mask_bits");
		wr(rcso_pkg::RCSO_CNT_OFS[1], 32'h7FFFFFFF);
		ev(7'h20, 16'h0010, 16'h0001);
		chk("irq_masked", {31'h0, irq}, 32'h0);
		wr(rcso_pkg::RCSO_MASK_OFS, 32'h0);
		chk("irq_unmask", {31'h0, irq}, 32'h1);
		rd(rcso_pkg::RCSO_CNT_OFS[7], 32'h10, "ipv4_bytes");
		rd(rcso_pkg::RCSO_STATUS_OFS, 32'h2, "stat_masked");
		$display("test mask done");
		// Status ignores writes; reserved and unmapped places read zero
		wr(rcso_pkg::RCSO_STATUS_OFS, 32'hFFFFFFFF);
		rd(rcso_pkg::RCSO_STATUS_OFS, 32'h0, "stat_write");
		wr(12'h204, 32'h12345678);
		rd(12'h204, 32'h0, "unmapped");
		$display("test refusals done");
		// Reset in mid-run must clear counters and mask again
		wr(rcso_pkg::RCSO_MASK_OFS, 32'h00000001);
		@(posedge core_clk);
		reset_n <= 1'b0;
		repeat (5) @(posedge core_clk);
		reset_n <= 1'b1;
		rd(rcso_pkg::RCSO_CNT_OFS[7], 32'h0, "cnt_rst2");
		rd(rcso_pkg::RCSO_MASK_OFS, 32'h0, "mask_rst2");
		chk("irq_rst2", {31'h0, irq}, 32'h0);
		$display("test mid reset done");
		print_verdict();
	end
endmodule : rcso_stats_tb
`default_nettype wire
